// >>> cma_core_model.sv
// model of the instruction core that issues requests to the unit
// assumes the bench calls its tasks; each request starts at a falling edge
`timescale 1ns/1ns
module cma_core_model
    import cma_pkg::*;
#(
    parameter int FLASH_AW = FLASH_AW_DEF
) (
    input  wire logic           core_clk,
    output logic                acc_req,
    output cma_mode_t           acc_mode,
    output logic [7:0]          acc_addr,
    output logic                acc_we,
    output logic [7:0]          acc_wdata,
    output logic [BANK_W-1:0]   psw_bank,
    output cma_stk_t            stk_op,
    output logic [15:0]         stk_wdata,
    output logic                tbl_req,
    output logic                dbg_rd,
    output logic                dbg_we,
    output logic [FLASH_AW-1:0] dbg_addr,
    output logic [7:0]          dbg_wdata,
    output logic                security_en,
    output logic                isp_we,
    output logic [FLASH_AW-1:0] isp_addr,
    output logic [7:0]          isp_wdata
);
    // idle values from time zero
    initial begin
        {acc_req, acc_we, acc_addr, acc_wdata, psw_bank, stk_wdata, tbl_req} = '0;
        {dbg_rd, dbg_we, dbg_addr, dbg_wdata, security_en, isp_we, isp_addr, isp_wdata} = '0;
        acc_mode = CMA_DIRECT;
        stk_op = CMA_STK_NONE;
    end
    // one data access; the answer stands when the task returns
    task automatic acc(input cma_mode_t m, input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        @(negedge core_clk);
        {acc_req, acc_we, acc_addr, acc_wdata} = {1'b1, w, a, d};
        acc_mode = m;
        @(negedge core_clk);
        {acc_req, acc_we, acc_wdata} = {2'b00, ~d};
    endtask : acc
    // one stack step; no bound on depth is kept by the core
    task automatic stk(input cma_stk_t o, input logic [15:0] d);
        @(negedge core_clk);
        stk_op = o;
        stk_wdata = d;
        @(negedge core_clk);
        stk_op = CMA_STK_NONE;
        stk_wdata = ~d;
    endtask : stk
    // table read, debug access or self-program write
    task automatic fl(input logic t, r, w, s, input logic [FLASH_AW-1:0] a,
                      input logic [7:0] d);
        @(negedge core_clk);
        {tbl_req, dbg_rd, dbg_we, isp_we} = {t, r, w, s};
        {dbg_addr, isp_addr, dbg_wdata, isp_wdata} = {a, a, d, d};
        @(negedge core_clk);
        {tbl_req, dbg_rd, dbg_we, isp_we} = 4'h0;
    endtask : fl
endmodule : cma_core_model

// >>> cma_memory_addressing.sv
// data ram, pointer registers, stack and program flash of the core
// assumes the instruction core drives every request input on core_clk
//
// What this block does
// - A direct access below 0x80 reaches the internal ram byte of the same address.
// - A direct access from 0x80 up reaches the special-function space instead of ram.
// - Ram bytes 0x00 to 0x1f form four banks of eight working registers.
// - Bit access works on ram bytes 0x20 to 0x2f and on special registers ending in 0 or 8.
// - Indirect access reaches all 256 ram bytes; it and the stack are the only ways to the upper 128.
// - Program flash keeps code and tables at program addresses 0x0000 to 0x0fff.
// - Program flash can be written both by the debug tool and by in-system programming.
// - With security on, every debug read-out of program flash returns 0x00.
// - One 16-bit data pointer made of a high and a low byte addresses table reads.
// - The stack pointer resets to 0x07 so the first pushed byte lands at 0x08.
// - A push adds one to the stack pointer; calls and interrupt entry push two bytes.
// - A pop takes one from the stack pointer; returns take two.
// - Data pointer low and high are read-write special registers at 0x82 and 0x83, reset to 0.
`timescale 1ns/1ns
module cma_memory_addressing
    import cma_pkg::*;
#(
    parameter int FLASH_AW = FLASH_AW_DEF
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // data access
    input  wire logic                  acc_req,
    input  wire cma_mode_t             acc_mode,
    input  wire logic [7:0]            acc_addr,
    input  wire logic                  acc_we,
    input  wire logic [7:0]            acc_wdata,
    input  wire logic [BANK_W-1:0]     psw_bank,
    output logic [7:0]                 acc_rdata,
    output logic                       acc_rvalid,
    // stack
    input  wire cma_stk_t              stk_op,
    input  wire logic [15:0]           stk_wdata,
    output logic [15:0]                stk_rdata,
    output logic                       stk_rvalid,
    output logic [7:0]                 stack_pointer,
    // table read through the data pointer
    input  wire logic                  tbl_req,
    output logic [7:0]                 tbl_rdata,
    output logic                       tbl_rvalid,
    output logic [15:0]                table_read_pointer,
    // debug tool port
    input  wire logic                  dbg_rd,
    input  wire logic                  dbg_we,
    input  wire logic [FLASH_AW-1:0]   dbg_addr,
    input  wire logic [7:0]            dbg_wdata,
    input  wire logic                  security_en,
    output logic [7:0]                 dbg_rdata,
    output logic                       dbg_rvalid,
    // in-system programming write port
    input  wire logic                  isp_we,
    input  wire logic [FLASH_AW-1:0]   isp_addr,
    input  wire logic [7:0]            isp_wdata
);

    localparam int FLASH_DEPTH = 1 << FLASH_AW;

    // flash size must fit the 16-bit pointer
    if (FLASH_AW < 1 || FLASH_AW > 16) begin : g_chk_aw
        $error("FLASH_AW must lie in 1..16");
    end

    cma_state_t  s_q;
    cma_state_t  s_d;

    logic [7:0]  internal_data_ram [RAM_DEPTH];
    logic [7:0]  program_flash     [FLASH_DEPTH];

    // ram write ports, two so a two-byte push finishes in one cycle
    logic        ram_we0;
    logic [7:0]  ram_a0;
    logic [7:0]  ram_d0;
    logic        ram_we1;
    logic [7:0]  ram_a1;
    logic [7:0]  ram_d1;

    logic [7:0]  byte_a;
    logic        is_sfr;
    logic [7:0]  sfr_rd;
    logic [7:0]  cur;
    logic [7:0]  wbyte;
    logic [15:0] dptr;
    logic        tbl_in_range;
    logic [7:0]  sp_p1;
    logic [7:0]  sp_p2;
    logic [7:0]  sp_m1;

    // byte address of the access
    always_comb begin
        byte_a = acc_addr;
        unique case (acc_mode)
            CMA_WREG: begin
                byte_a = {{(8-BANK_W-REG_IDX_W){1'b0}}, psw_bank,
                          acc_addr[REG_IDX_W-1:0]};
            end
            CMA_BIT: begin
                if (acc_addr[7]) begin
                    byte_a = {acc_addr[7:3], 3'b000};
                end else begin
                    byte_a = BIT_RAM_BASE + {4'h0, acc_addr[6:3]};
                end
            end
            default: begin
                byte_a = acc_addr;
            end
        endcase
    end

    // direct and bit accesses at 0x80 and up go to special space
    assign is_sfr = (acc_mode == CMA_DIRECT || acc_mode == CMA_BIT)
                    && (byte_a >= SFR_BASE);

    // special registers held here; the rest reads zero
    always_comb begin
        unique case (byte_a)
            ADDR_SP:  sfr_rd = s_q.sp;
            ADDR_DPL: sfr_rd = s_q.data_pointer_low;
            ADDR_DPH: sfr_rd = s_q.data_pointer_high;
            default:  sfr_rd = SFR_IDLE;
        endcase
    end

    // current byte at the access address
    assign cur = is_sfr ? sfr_rd : internal_data_ram[byte_a];

    // byte to store: whole byte, or one bit merged into it
    always_comb begin
        wbyte = acc_wdata;
        if (acc_mode == CMA_BIT) begin
            wbyte = cur;
            wbyte[acc_addr[2:0]] = acc_wdata[0];
        end
    end

    // data pointer and flash range check
    assign dptr         = {s_q.data_pointer_high, s_q.data_pointer_low};
    assign tbl_in_range = (dptr >> FLASH_AW) == 16'h0000;

    // stack pointer neighbours, wrapping with no check
    assign sp_p1 = s_q.sp + 8'h01;
    assign sp_p2 = s_q.sp + 8'h02;
    assign sp_m1 = s_q.sp - 8'h01;

    // next state and ram writes
    always_comb begin
        s_d           = s_q;
        s_d.rvalid    = 1'b0;
        s_d.stk_valid = 1'b0;
        s_d.tbl_valid = 1'b0;
        s_d.dbg_valid = 1'b0;
        ram_we0       = 1'b0;
        ram_a0        = 8'h00;
        ram_d0        = 8'h00;
        ram_we1       = 1'b0;
        ram_a1        = 8'h00;
        ram_d1        = 8'h00;

        // a stack operation takes the ram and drops a data access
        unique case (stk_op)
            CMA_STK_PUSH1: begin
                s_d.sp  = sp_p1;
                ram_we0 = 1'b1;
                ram_a0  = sp_p1;
                ram_d0  = stk_wdata[7:0];
            end
            CMA_STK_PUSH2: begin
                s_d.sp  = sp_p2;
                ram_we0 = 1'b1;
                ram_a0  = sp_p1;
                ram_d0  = stk_wdata[7:0];
                ram_we1 = 1'b1;
                ram_a1  = sp_p2;
                ram_d1  = stk_wdata[15:8];
            end
            CMA_STK_POP1: begin
                s_d.sp        = sp_m1;
                s_d.stk_rdata = {8'h00, internal_data_ram[s_q.sp]};
                s_d.stk_valid = 1'b1;
            end
            CMA_STK_POP2: begin
                s_d.sp        = s_q.sp - 8'h02;
                s_d.stk_rdata = {internal_data_ram[s_q.sp],
                                 internal_data_ram[sp_m1]};
                s_d.stk_valid = 1'b1;
            end
            default: begin
                if (acc_req) begin
                    s_d.rvalid = 1'b1;
                    if (acc_mode == CMA_BIT) begin
                        s_d.rdata = {7'h00, cur[acc_addr[2:0]]};
                    end else begin
                        s_d.rdata = cur;
                    end
                    if (acc_we && is_sfr) begin
                        unique case (byte_a)
                            ADDR_SP:  s_d.sp  = wbyte;
                            ADDR_DPL: s_d.data_pointer_low = wbyte;
                            ADDR_DPH: s_d.data_pointer_high = wbyte;
                            default:  s_d.sp  = s_q.sp;
                        endcase
                    end else if (acc_we) begin
                        ram_we0 = 1'b1;
                        ram_a0  = byte_a;
                        ram_d0  = wbyte;
                    end
                end
            end
        endcase

        // table read through the data pointer
        if (tbl_req) begin
            s_d.tbl_valid = 1'b1;
            if (tbl_in_range) begin
                s_d.tbl_data = program_flash[dptr[FLASH_AW-1:0]];
            end else begin
                s_d.tbl_data = 8'h00;
            end
        end

        // debug read-out, blanked when secured
        if (dbg_rd) begin
            s_d.dbg_valid = 1'b1;
            if (security_en) begin
                s_d.dbg_rdata = SECURE_BYTE;
            end else begin
                s_d.dbg_rdata = program_flash[dbg_addr];
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q           <= '0;
            s_q.sp        <= SP_RST;
            s_q.data_pointer_low       <= DPL_RST;
            s_q.data_pointer_high       <= DPH_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // internal ram, contents not reset
    always_ff @(posedge core_clk) begin
        if (ram_we0) begin
            internal_data_ram[ram_a0] <= ram_d0;
        end
        if (ram_we1) begin
            internal_data_ram[ram_a1] <= ram_d1;
        end
    end

    // program flash, kept across reset; debug wins over self-programming
    always_ff @(posedge core_clk) begin
        if (dbg_we) begin
            program_flash[dbg_addr] <= dbg_wdata;
        end else if (isp_we) begin
            program_flash[isp_addr] <= isp_wdata;
        end
    end

    // outputs straight from the state register
    assign acc_rdata          = s_q.rdata;
    assign acc_rvalid         = s_q.rvalid;
    assign stk_rdata          = s_q.stk_rdata;
    assign stk_rvalid         = s_q.stk_valid;
    assign stack_pointer      = s_q.sp;
    assign tbl_rdata          = s_q.tbl_data;
    assign tbl_rvalid         = s_q.tbl_valid;
    assign table_read_pointer = {s_q.data_pointer_high, s_q.data_pointer_low};
    assign dbg_rdata          = s_q.dbg_rdata;
    assign dbg_rvalid         = s_q.dbg_valid;

endmodule : cma_memory_addressing

// >>> cma_memory_addressing_assertions.sv
// port-level timing checks of the addressing unit
// assumes binding to the unit's top module, one clock domain
`timescale 1ns/1ns
module cma_memory_addressing_assertions
    import cma_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        acc_req,
    input wire cma_mode_t   acc_mode,
    input wire logic [7:0]  acc_addr,
    input wire logic        acc_we,
    input wire logic [7:0]  acc_wdata,
    input wire logic [7:0]  acc_rdata,
    input wire logic        acc_rvalid,
    input wire cma_stk_t    stk_op,
    input wire logic        stk_rvalid,
    input wire logic [7:0]  stack_pointer,
    input wire logic        tbl_req,
    input wire logic        tbl_rvalid,
    input wire logic [15:0] table_read_pointer,
    input wire logic        dbg_rd,
    input wire logic        security_en,
    input wire logic [7:0]  dbg_rdata,
    input wire logic        dbg_rvalid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // a data access taken at this edge
    sequence s_acc;
        acc_req && stk_op == CMA_STK_NONE;
    endsequence
    // a direct access taken at this edge
    sequence s_dir;
        s_acc ##0 acc_mode == CMA_DIRECT;
    endsequence
    // answer timing and the special space
    AST_ACC_ANSWER: assert property (s_acc |=> acc_rvalid)
        else $error("data access without answer");
    AST_ACC_DROP: assert property (!(acc_req && stk_op == CMA_STK_NONE) |=> !acc_rvalid)
        else $error("answer without access");
    AST_SFR_ZERO: assert property (s_dir ##0 acc_addr > ADDR_DPH |=> acc_rdata == 8'h00)
        else $error("unassigned special address not zero");
    AST_DPL_WRITE: assert property (s_dir ##0 acc_we && acc_addr == ADDR_DPL
        |=> table_read_pointer[7:0] == $past(acc_wdata))
        else $error("pointer low byte not written");
    // stack pointer steps
    AST_SP_RESET: assert property ($rose(reset_n) |-> stack_pointer == 8'h07)
        else $error("stack pointer reset value");
    AST_PUSH1: assert property (stk_op == CMA_STK_PUSH1
        |=> stack_pointer == $past(stack_pointer) + 8'h01)
        else $error("push did not add one");
    AST_PUSH2: assert property (stk_op == CMA_STK_PUSH2
        |=> stack_pointer == $past(stack_pointer) + 8'h02)
        else $error("call push did not add two");
    AST_POP1: assert property (stk_op == CMA_STK_POP1
        |=> stk_rvalid && stack_pointer == $past(stack_pointer) - 8'h01)
        else $error("pop did not take one");
    AST_POP2: assert property (stk_op == CMA_STK_POP2
        |=> stk_rvalid && stack_pointer == $past(stack_pointer) - 8'h02)
        else $error("return did not take two");
    // table and debug read answers
    AST_TBL: assert property (tbl_req |=> tbl_rvalid)
        else $error("table read without answer");
    AST_SECURE: assert property (dbg_rd && security_en |=> dbg_rvalid && dbg_rdata == 8'h00)
        else $error("secured read-out not blank");
endmodule : cma_memory_addressing_assertions

// >>> cma_memory_addressing_tb.sv
// self-checking bench of the addressing unit
// assumes the core model drives every request input
`timescale 1ns/1ns
module cma_memory_addressing_tb;
    import cma_pkg::*;
    logic core_clk, reset_n, acc_req, acc_we, tbl_req, dbg_rd, dbg_we, security_en, isp_we;
    logic acc_rvalid, stk_rvalid, tbl_rvalid, dbg_rvalid;
    cma_mode_t acc_mode;
    cma_stk_t stk_op;
    logic [1:0] psw_bank;
    logic [7:0] acc_addr, acc_wdata, acc_rdata, dbg_wdata, isp_wdata, tbl_rdata, dbg_rdata;
    logic [7:0] stack_pointer;
    logic [11:0] dbg_addr, isp_addr;
    logic [15:0] stk_wdata, stk_rdata, table_read_pointer;
    int fails = 0;
    int total_checks = 0;
    cma_memory_addressing dut (.*);
    cma_core_model core (.*);
    // clock and a hang limit
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // lower ram, special space and upper ram
    task automatic t_ram();
        core.acc(CMA_DIRECT, 8'h7f, 1'b1, 8'h3c);
        core.acc(CMA_INDIRECT, 8'h7f, 1'b0, 8'h00);
        chk("low ram", 16'h3c, acc_rdata);
        core.acc(CMA_INDIRECT, 8'h90, 1'b1, 8'ha5);
        core.acc(CMA_DIRECT, 8'h90, 1'b1, 8'h11);
        core.acc(CMA_DIRECT, 8'h90, 1'b0, 8'h00);
        chk("sfr 90", 16'h00, acc_rdata);
        core.acc(CMA_INDIRECT, 8'h90, 1'b0, 8'h00);
        chk("high ram", 16'ha5, acc_rdata);
        $display("t_ram done");
    endtask : t_ram
    // banks and bit access
    task automatic t_bank();
        for (int b = 0; b < 4; b++) begin
            core.psw_bank = 2'(b);
            core.acc(CMA_WREG, 8'h05, 1'b1, 8'h40 + 8'(b));
        end
        for (int b = 0; b < 4; b++) begin
            core.acc(CMA_INDIRECT, {3'h0, 2'(b), 3'h5}, 1'b0, 8'h00);
            chk("bank reg", 16'h40 + 16'(b), acc_rdata);
        end
        core.acc(CMA_DIRECT, 8'h21, 1'b1, 8'h00);
        core.acc(CMA_BIT, 8'h0b, 1'b1, 8'h01);
        core.acc(CMA_DIRECT, 8'h21, 1'b0, 8'h00);
        chk("bit byte", 16'h08, acc_rdata);
        $display("t_bank done");
    endtask : t_bank
    // stack moved to 0xbf, call and return pairs
    task automatic t_stack();
        chk("sp reset", 16'h07, stack_pointer);
        core.acc(CMA_DIRECT, ADDR_SP, 1'b1, 8'hbf);
        core.stk(CMA_STK_PUSH2, 16'h1234);
        core.stk(CMA_STK_PUSH1, 16'h0077);
        chk("sp push", 16'hc2, stack_pointer);
        core.acc(CMA_INDIRECT, 8'hc0, 1'b0, 8'h00);
        chk("call low", 16'h34, acc_rdata);
        core.stk(CMA_STK_POP1, 16'h0000);
        chk("pop", 16'h0077, stk_rdata);
        core.stk(CMA_STK_POP2, 16'h0000);
        chk("ret", 16'h1234, stk_rdata);
        chk("sp ret", 16'hbf, stack_pointer);
        $display("t_stack done");
    endtask : t_stack
    // data pointer, table read, debug and self-program
    task automatic t_flash();
        chk("dptr reset", 16'h0000, table_read_pointer);
        core.fl(1'b0, 1'b0, 1'b0, 1'b1, 12'h134, 8'ha5);
        core.acc(CMA_DIRECT, ADDR_DPL, 1'b1, 8'h34);
        core.acc(CMA_DIRECT, ADDR_DPH, 1'b1, 8'h01);
        chk("dptr", 16'h0134, table_read_pointer);
        core.acc(CMA_DIRECT, ADDR_DPH, 1'b0, 8'h00);
        chk("dph read", 16'h01, acc_rdata);
        core.fl(1'b1, 1'b0, 1'b0, 1'b0, 12'h000, 8'h00);
        chk("table", 16'ha5, tbl_rdata);
        core.fl(1'b0, 1'b0, 1'b1, 1'b0, 12'hfff, 8'h5a);
        core.fl(1'b0, 1'b1, 1'b0, 1'b0, 12'hfff, 8'h00);
        chk("dbg read", 16'h5a, dbg_rdata);
        core.security_en = 1'b1;
        core.fl(1'b0, 1'b1, 1'b0, 1'b0, 12'hfff, 8'h00);
        chk("secured", 16'h00, dbg_rdata);
        $display("t_flash done");
    endtask : t_flash
    // reset, then each scenario
    initial begin
        reset_n = 1'b0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        t_ram();
        t_bank();
        t_stack();
        t_flash();
        tally_and_finish();
    end
endmodule : cma_memory_addressing_tb
bind cma_memory_addressing cma_memory_addressing_assertions chk_i (.*);

// >>> cma_pkg.sv
// constants and types of the core's memory addressing unit
// assumes one core clock and an instruction core that issues one access per cycle
package cma_pkg;

    // special-function space and the pointer registers held here
    localparam logic [7:0] SFR_BASE     = 8'h80;
    localparam logic [7:0] ADDR_SP      = 8'h81;
    localparam logic [7:0] ADDR_DPL     = 8'h82;
    localparam logic [7:0] ADDR_DPH     = 8'h83;
    localparam logic [7:0] SFR_IDLE     = 8'h00;

    // reset values
    localparam logic [7:0] SP_RST       = 8'h07;
    localparam logic [7:0] DPL_RST      = 8'h00;
    localparam logic [7:0] DPH_RST      = 8'h00;

    // internal ram regions
    localparam int         RAM_DEPTH    = 256;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam int         BANK_W       = 2;
    localparam int         REG_IDX_W    = 3;

    // program flash
    localparam int         FLASH_AW_DEF = 12;
    localparam logic [15:0] FLASH_TOP   = 16'h0fff;
    localparam logic [7:0] SECURE_BYTE  = 8'h00;

    // kind of data access
    typedef enum logic [1:0] {
        CMA_DIRECT   = 2'b00,
        CMA_INDIRECT = 2'b01,
        CMA_WREG     = 2'b10,
        CMA_BIT      = 2'b11
    } cma_mode_t;

    // stack operation
    typedef enum logic [2:0] {
        CMA_STK_NONE  = 3'b000,
        CMA_STK_PUSH1 = 3'b001,
        CMA_STK_PUSH2 = 3'b010,
        CMA_STK_POP1  = 3'b011,
        CMA_STK_POP2  = 3'b100
    } cma_stk_t;

    // flip-flop state of the unit apart from the ram and flash arrays
    typedef struct packed {
        logic [7:0]  sp;
        logic [7:0]  data_pointer_low;
        logic [7:0]  data_pointer_high;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [15:0] stk_rdata;
        logic        stk_valid;
        logic [7:0]  tbl_data;
        logic        tbl_valid;
        logic [7:0]  dbg_rdata;
        logic        dbg_valid;
    } cma_state_t;

endpackage : cma_pkg
